// *** core/bfsr_pkg.sv ***
// constants shared by the break framed slot receiver
package bfsr_pkg;
   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int CLK_HZ = 20_000_000;
   localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
   localparam int BIT_NS = 4000;
   localparam int BIT_CYC = BIT_NS / CLK_NS;
   localparam int HALF_BIT_CYC = BIT_CYC / 2;
   localparam int BREAK_MIN_NS = 88000;
   localparam int TICK_DIV = 133;
   localparam int TICK_NS = TICK_DIV * CLK_NS;
   // rounded down so a low of exactly the minimum break is still caught
   localparam int BRK_TICKS = BREAK_MIN_NS / TICK_NS;
   localparam logic [7:0] BRK_COMPARE = 8'hff;
   localparam logic [7:0] BRK_POLY = 8'h00;
   // -----------------------------------------------------------------
   // register map and fields
   // -----------------------------------------------------------------
   localparam logic [8:0] REG_CTRL = 9'h000;
   localparam logic [8:0] REG_FIRST_SLOT = 9'h001;
   localparam logic [8:0] REG_BUF_BASE = 9'h002;
   localparam logic [8:0] REG_BUF_SIZE = 9'h003;
   localparam logic [8:0] REG_BUS_ACT = 9'h004;
   localparam logic [8:0] REG_SLOT_ACT = 9'h005;
   localparam logic [8:0] REG_START_CODE = 9'h006;
   localparam logic [8:0] REG_STATUS = 9'h007;
   localparam int CTRL_RX_EN_BIT = 0;
   localparam int CTRL_BRK_EN_BIT = 1;
   localparam int CTRL_FLIP_BIT = 2;
   localparam int RAM_SEL_BIT = 8;
   // -----------------------------------------------------------------
   // reset values and codes
   // -----------------------------------------------------------------
   localparam logic [2:0] CTRL_RESET = 3'h0;
   localparam logic [9:0] FIRST_SLOT_RESET = 10'h001;
   localparam logic [9:0] FIRST_SLOT_MAX = 10'h200;
   localparam logic [8:0] BUF_SIZE_MAX = 9'h100;
   localparam logic [7:0] BREAK_SEEN_CODE = 8'h01;
   localparam logic [7:0] START_CODE_SEEN_CODE = 8'h02;
   typedef enum logic [2:0] {
      RX_IDLE = 3'b000,
      RX_START = 3'b001,
      RX_DATA = 3'b010,
      RX_STOP = 3'b011,
      RX_WAIT_HIGH = 3'b100
   } bfsr_rx_state_type;
endpackage

// *** core/bfsr_slot_ram.sv ***
// capture buffer memory with registered read data
`timescale 1ns/1ps
module bfsr_slot_ram #(
   parameter int DEPTH = 256,
   parameter int AW = 8
) (
   input wire logic clk_i,
   input wire logic ce_i,
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [7:0] wdata_i,
   input wire logic [AW-1:0] raddr_i,
   output logic [7:0] rdata_o
);
   logic [7:0] mem [DEPTH];
   if (DEPTH != (1 << AW)) $error("slot ram depth must be two to the address width");
   // -----------------------------------------------------------------
   // write and registered read
   // -----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (ce_i && we_i)
      begin
         mem[waddr_i] <= wdata_i;
      end
      if (ce_i)
      begin
         rdata_o <= mem[raddr_i];
      end
   end
endmodule

// *** core/bfsr_break_det.sv ***
// break width detector: counts low time in slow ticks
`timescale 1ns/1ps
module bfsr_break_det (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic en_i,
   input wire logic line_i,
   output logic hit_o
);
   logic [7:0] div_reg;
   logic [7:0] cnt_reg;
   logic tick;
   if (bfsr_pkg::BRK_POLY != 8'h00) $error("break counter needs a zero feedback term");
   if (bfsr_pkg::BRK_TICKS >= 255 || bfsr_pkg::TICK_DIV > 255) $error("break ticks do not fit");
   // prescaler restarts with each low so ticks align to the falling edge
   assign tick = (div_reg == 8'(bfsr_pkg::TICK_DIV - 1));
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         div_reg <= 8'h00;
      else if (ce_i)
         div_reg <= (!en_i || line_i || tick) ? 8'h00 : div_reg + 8'h01;
   end
   // zero feedback reduces the shift counter to a plain down count
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         cnt_reg <= bfsr_pkg::BRK_COMPARE;
      else if (ce_i)
      begin
         if (!en_i || line_i)
            cnt_reg <= bfsr_pkg::BRK_COMPARE;
         else if (tick && cnt_reg != 8'h00)
            cnt_reg <= cnt_reg - 8'h01;
      end
   end
   // one pulse per low period once it reaches the break width
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         hit_o <= 1'b0;
      else if (ce_i)
         hit_o <= en_i && !line_i && tick &&
            (cnt_reg == bfsr_pkg::BRK_COMPARE - 8'(bfsr_pkg::BRK_TICKS - 1));
   end
   brk_low_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      hit_o |-> !$past(line_i, 1) && !$past(line_i, 8) && !$past(line_i, 200))
      else $error("break reported without a long low");
endmodule

// *** core/bfsr_top.sv ***
// break framed slot receiver: byte receiver, capture logic and registers
`timescale 1ns/1ps
module bfsr_top #(
   parameter int BUF_DEPTH = 256
) (
   input wire logic SYS_CLK_I,
   input wire logic NRST_I,
   input wire logic CE_I,
   input wire logic SERIAL_LINE_IN_I,
   input wire logic [8:0] ADDR_I,
   input wire logic [15:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [15:0] RDATA_O,
   output logic BREAK_EVT_O,
   output logic BYTE_EVT_O
);
   if (BUF_DEPTH != 256) $error("buffer depth must be 256");
   if (bfsr_pkg::BIT_CYC < 8 || bfsr_pkg::BIT_CYC > 127) $error("bit time out of range");

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   logic [2:0] ctrl_reg;
   logic [9:0] first_slot_reg;
   logic [9:0] first_active_reg;
   logic [7:0] buf_base_reg;
   logic [8:0] buf_size_reg;
   logic [7:0] bus_act_reg;
   logic slot_act_reg;
   logic [7:0] start_code_reg;
   logic run;
   logic line;
   logic brk_hit;
   bfsr_pkg::bfsr_rx_state_type rx_state_reg;
   logic [6:0] tmr_reg;
   logic [2:0] bit_reg;
   logic [7:0] shift_reg;
   logic byte_ok_reg;
   logic ferr_reg;
   logic [7:0] byte_reg;
   logic [9:0] slot_cnt_reg;
   logic [8:0] wr_idx_reg;
   logic pkt_live_reg;
   logic armed_reg;
   logic store;
   logic take;
   logic is_start_code;
   logic [7:0] ram_waddr;
   logic [7:0] ram_q;
   logic [15:0] reg_q_reg;
   logic ram_sel_reg;
   logic cfg_buf_wr;
   logic act_rd;
   logic slot_rd;

   // address match for a strobed access
   function automatic logic hit_reg(input logic strobe, input logic [8:0] a,
      input logic [8:0] r);
      hit_reg = strobe && (a == r);
   endfunction

   // -----------------------------------------------------------------
   // line conditioning and enables
   // -----------------------------------------------------------------
   // both parts see the same optionally inverted line
   assign line = SERIAL_LINE_IN_I ^ ctrl_reg[bfsr_pkg::CTRL_FLIP_BIT];
   assign run = ctrl_reg[bfsr_pkg::CTRL_RX_EN_BIT] && ctrl_reg[bfsr_pkg::CTRL_BRK_EN_BIT];

   bfsr_break_det u_break_det (
      .clk_i(SYS_CLK_I),
      .nrst_i(NRST_I),
      .ce_i(CE_I),
      .en_i(run),
      .line_i(line),
      .hit_o(brk_hit)
   );

   // -----------------------------------------------------------------
   // byte receiver
   // -----------------------------------------------------------------
   // start found mid bit, then samples every bit time, no parity
   always_ff @(posedge SYS_CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         rx_state_reg <= bfsr_pkg::RX_IDLE;
         tmr_reg <= 7'h00;
         bit_reg <= 3'h0;
         shift_reg <= 8'h00;
      end
      else if (CE_I)
      begin
         if (!run)
            rx_state_reg <= bfsr_pkg::RX_IDLE;
         else
         begin
            case (rx_state_reg)
               bfsr_pkg::RX_IDLE:
               begin
                  if (!line)
                  begin
                     rx_state_reg <= bfsr_pkg::RX_START;
                     tmr_reg <= 7'(bfsr_pkg::HALF_BIT_CYC - 1);
                  end
               end
               bfsr_pkg::RX_START:
               begin
                  if (tmr_reg != 7'h00)
                     tmr_reg <= tmr_reg - 7'h01;
                  else if (!line)
                  begin
                     rx_state_reg <= bfsr_pkg::RX_DATA;
                     tmr_reg <= 7'(bfsr_pkg::BIT_CYC - 1);
                     bit_reg <= 3'h0;
                  end
                  else
                     rx_state_reg <= bfsr_pkg::RX_IDLE; // glitch, not a start
               end
               bfsr_pkg::RX_DATA:
               begin
                  if (tmr_reg != 7'h00)
                     tmr_reg <= tmr_reg - 7'h01;
                  else
                  begin
                     shift_reg <= {line, shift_reg[7:1]};
                     bit_reg <= bit_reg + 3'h1;
                     tmr_reg <= 7'(bfsr_pkg::BIT_CYC - 1);
                     if (bit_reg == 3'h7)
                        rx_state_reg <= bfsr_pkg::RX_STOP;
                  end
               end
               bfsr_pkg::RX_STOP:
               begin
                  if (tmr_reg != 7'h00)
                     tmr_reg <= tmr_reg - 7'h01;
                  else if (line)
                     rx_state_reg <= bfsr_pkg::RX_IDLE;
                  else
                     rx_state_reg <= bfsr_pkg::RX_WAIT_HIGH;
               end
               bfsr_pkg::RX_WAIT_HIGH:
               begin
                  if (line)
                     rx_state_reg <= bfsr_pkg::RX_IDLE;
               end
               default:
                  rx_state_reg <= bfsr_pkg::RX_IDLE;
            endcase
         end
      end
   end

   // completed byte or framing error, one cycle pulses
   always_ff @(posedge SYS_CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         byte_ok_reg <= 1'b0;
         ferr_reg <= 1'b0;
         byte_reg <= 8'h00;
      end
      else if (CE_I)
      begin
         byte_ok_reg <= 1'b0;
         ferr_reg <= 1'b0;
         if (run && rx_state_reg == bfsr_pkg::RX_STOP && tmr_reg == 7'h00)
         begin
            byte_ok_reg <= line;
            ferr_reg <= !line;
            if (line)
               byte_reg <= shift_reg;
         end
      end
   end

   // event pulses for break and for each good byte
   always_ff @(posedge SYS_CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         BREAK_EVT_O <= 1'b0;
         BYTE_EVT_O <= 1'b0;
      end
      else if (CE_I)
      begin
         BREAK_EVT_O <= brk_hit;
         BYTE_EVT_O <= byte_ok_reg;
      end
   end

   // -----------------------------------------------------------------
   // packet tracking and capture
   // -----------------------------------------------------------------
   assign cfg_buf_wr = hit_reg(WR_I, ADDR_I, bfsr_pkg::REG_BUF_BASE) ||
      hit_reg(WR_I, ADDR_I, bfsr_pkg::REG_BUF_SIZE);
   assign is_start_code = byte_ok_reg && pkt_live_reg && slot_cnt_reg == 10'h000;
   // a bad slot still uses its position so later slots stay aligned
   assign take = (byte_ok_reg || ferr_reg) && armed_reg && slot_cnt_reg != 10'h000 &&
      slot_cnt_reg >= first_active_reg && wr_idx_reg < buf_size_reg;
   assign store = take && byte_ok_reg;
   assign ram_waddr = buf_base_reg + wr_idx_reg[7:0];

   // slot counter: start code is slot zero, saturates past the last slot
   always_ff @(posedge SYS_CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
         slot_cnt_reg <= 10'h000;
      else if (CE_I)
      begin
         if (brk_hit)
            slot_cnt_reg <= 10'h000;
         else if ((byte_ok_reg || ferr_reg) && slot_cnt_reg != 10'h3ff)
            slot_cnt_reg <= slot_cnt_reg + 10'h001;
      end
   end

   // packet flags: live after a break, armed unless buffer base or size written
   always_ff @(posedge SYS_CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         pkt_live_reg <= 1'b0;
         armed_reg <= 1'b0;
      end
      else if (CE_I)
      begin
         if (!run)
         begin
            pkt_live_reg <= 1'b0;
            armed_reg <= 1'b0;
         end
         else if (brk_hit)
         begin
            pkt_live_reg <= 1'b1;
            armed_reg <= 1'b1;
         end
         else if (cfg_buf_wr)
            armed_reg <= 1'b0;
      end
   end

   // first slot index latched only at a break
   always_ff @(posedge SYS_CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
         first_active_reg <= bfsr_pkg::FIRST_SLOT_RESET;
      else if (CE_I && brk_hit)
         first_active_reg <= first_slot_reg;
   end

   // write index into the buffer
   always_ff @(posedge SYS_CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
         wr_idx_reg <= 9'h000;
      else if (CE_I)
      begin
         if (brk_hit)
            wr_idx_reg <= 9'h000;
         else if (take)
            wr_idx_reg <= wr_idx_reg + 9'h001;
      end
   end

   bfsr_slot_ram #(
      .DEPTH(BUF_DEPTH),
      .AW(8)
   ) u_slot_ram (
      .clk_i(SYS_CLK_I),
      .ce_i(CE_I),
      .we_i(store),
      .waddr_i(ram_waddr),
      .wdata_i(byte_reg),
      .raddr_i(ADDR_I[7:0]),
      .rdata_o(ram_q)
   );

   // start code holder
   always_ff @(posedge SYS_CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
         start_code_reg <= 8'h00;
      else if (CE_I && is_start_code)
         start_code_reg <= byte_reg;
   end

   // -----------------------------------------------------------------
   // activity flags, read to clear, a new event wins over the clear
   // -----------------------------------------------------------------
   assign act_rd = hit_reg(RD_I, ADDR_I, bfsr_pkg::REG_BUS_ACT);
   assign slot_rd = hit_reg(RD_I, ADDR_I, bfsr_pkg::REG_SLOT_ACT);

   always_ff @(posedge SYS_CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
         bus_act_reg <= 8'h00;
      else if (CE_I)
      begin
         if (is_start_code)
            bus_act_reg <= bfsr_pkg::START_CODE_SEEN_CODE;
         else if (brk_hit)
            bus_act_reg <= bfsr_pkg::BREAK_SEEN_CODE;
         else if (act_rd)
            bus_act_reg <= 8'h00;
      end
   end

   always_ff @(posedge SYS_CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
         slot_act_reg <= 1'b0;
      else if (CE_I)
      begin
         if (store && wr_idx_reg + 9'h001 == buf_size_reg)
            slot_act_reg <= 1'b1;
         else if (slot_rd)
            slot_act_reg <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // register writes
   // -----------------------------------------------------------------
   always_ff @(posedge SYS_CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         ctrl_reg <= bfsr_pkg::CTRL_RESET;
         first_slot_reg <= bfsr_pkg::FIRST_SLOT_RESET;
         buf_base_reg <= 8'h00;
         buf_size_reg <= 9'h000;
      end
      else if (CE_I && WR_I)
      begin
         if (ADDR_I == bfsr_pkg::REG_CTRL)
            ctrl_reg <= WDATA_I[2:0];
         if (ADDR_I == bfsr_pkg::REG_FIRST_SLOT && WDATA_I[9:0] != 10'h000 &&
            WDATA_I[9:0] <= bfsr_pkg::FIRST_SLOT_MAX && WDATA_I[15:10] == 6'h00)
            first_slot_reg <= WDATA_I[9:0];
         if (ADDR_I == bfsr_pkg::REG_BUF_BASE)
            buf_base_reg <= WDATA_I[7:0];
         if (ADDR_I == bfsr_pkg::REG_BUF_SIZE && WDATA_I[8:0] <= bfsr_pkg::BUF_SIZE_MAX &&
            WDATA_I[15:9] == 7'h00)
            buf_size_reg <= WDATA_I[8:0];
      end
   end

   // -----------------------------------------------------------------
   // register reads, one cycle later
   // -----------------------------------------------------------------
   always_ff @(posedge SYS_CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         reg_q_reg <= 16'h0000;
         ram_sel_reg <= 1'b0;
      end
      else if (CE_I)
      begin
         ram_sel_reg <= RD_I && ADDR_I[bfsr_pkg::RAM_SEL_BIT];
         reg_q_reg <= 16'h0000;
         if (RD_I)
         begin
            case (ADDR_I)
               bfsr_pkg::REG_CTRL: reg_q_reg <= {13'h0000, ctrl_reg};
               bfsr_pkg::REG_FIRST_SLOT: reg_q_reg <= {6'h00, first_slot_reg};
               bfsr_pkg::REG_BUF_BASE: reg_q_reg <= {8'h00, buf_base_reg};
               bfsr_pkg::REG_BUF_SIZE: reg_q_reg <= {7'h00, buf_size_reg};
               bfsr_pkg::REG_BUS_ACT: reg_q_reg <= {8'h00, bus_act_reg};
               bfsr_pkg::REG_SLOT_ACT: reg_q_reg <= {15'h0000, slot_act_reg};
               bfsr_pkg::REG_START_CODE: reg_q_reg <= {8'h00, start_code_reg};
               bfsr_pkg::REG_STATUS: reg_q_reg <= {14'h0000, armed_reg, pkt_live_reg};
               default: reg_q_reg <= 16'h0000;
            endcase
         end
      end
   end
   assign RDATA_O = ram_sel_reg ? {8'h00, ram_q} : reg_q_reg;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   sequence good_stop_s;
      CE_I && run && rx_state_reg == bfsr_pkg::RX_STOP && tmr_reg == 7'h00 && line;
   endsequence
   sequence start_seen_s;
      CE_I && run && rx_state_reg == bfsr_pkg::RX_IDLE && !line;
   endsequence

   byte_on_stop_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
      good_stop_s |=> byte_ok_reg ##1 (BYTE_EVT_O || !$past(CE_I)))
      else $error("good stop bit gave no byte event");
   frame_err_drop_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
      ferr_reg |-> !store && !byte_ok_reg)
      else $error("framing error byte reached the buffer");
   start_wait_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
      start_seen_s ##1 (CE_I && !line) [*8] |-> rx_state_reg == bfsr_pkg::RX_START)
      else $error("start bit not held for its half bit");
   break_clears_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
      CE_I && brk_hit |=> slot_cnt_reg == 10'h000 && wr_idx_reg == 9'h000 && armed_reg)
      else $error("break did not restart the packet");
   first_latch_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
      CE_I && !brk_hit |=> first_active_reg == $past(first_active_reg))
      else $error("first slot changed outside a break");
   start_code_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
      CE_I && is_start_code |=> start_code_reg == $past(byte_reg) &&
         bus_act_reg == bfsr_pkg::START_CODE_SEEN_CODE)
      else $error("start code not held");
   act_clear_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
      CE_I && act_rd && !brk_hit && !is_start_code |=> bus_act_reg == 8'h00)
      else $error("bus activity not cleared by read");
   act_set_wins_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
      CE_I && act_rd && brk_hit && !is_start_code |=> bus_act_reg == bfsr_pkg::BREAK_SEEN_CODE)
      else $error("break lost against a read clear");
   disable_idle_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
      CE_I && !run |=> rx_state_reg == bfsr_pkg::RX_IDLE && !armed_reg ##1 !byte_ok_reg)
      else $error("receiver ran while disabled");
   full_stops_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
      store |-> wr_idx_reg < buf_size_reg && slot_cnt_reg >= first_active_reg)
      else $error("store past buffer end or before first slot");
   slot_flag_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
      CE_I && store && wr_idx_reg + 9'h001 == buf_size_reg |=> slot_act_reg)
      else $error("last slot did not raise slot activity");
endmodule

// *** dv/bfsr_tx_model.sv ***
// serial line transmitter model driving the slot receiver input
`timescale 1ns/1ps
module bfsr_tx_model (
   input wire logic clk_i,
   input wire logic flip_i,
   output logic line_o
);
   logic lvl;
   // line idles high, optional inversion on the wire
   assign line_o = lvl ^ flip_i;
   initial lvl = 1'b1;
   // hold one level for n clocks, changed just after an edge
   task automatic hold(input logic v, input int n);
      lvl <= v;
      repeat (n) @(posedge clk_i);
   endtask
   // one slot: low start, eight bits lsb first, stop, no parity
   task automatic send(input logic [7:0] d, input logic stop);
      hold(1'b0, bfsr_pkg::BIT_CYC);
      for (int i = 0; i < 8; i++)
         hold(d[i], bfsr_pkg::BIT_CYC);
      hold(stop, bfsr_pkg::BIT_CYC);
      if (!stop)
         hold(1'b1, 2 * bfsr_pkg::BIT_CYC);
   endtask
   // shortest break, then shortest mark after break; slots follow with no gap
   task automatic frame_start();
      hold(1'b0, 1760);
      hold(1'b1, 160);
   endtask
endmodule

// *** dv/tb.sv ***
// self-checking bench for the break framed slot receiver
`timescale 1ns/1ps
module tb;
   logic sys_clk, nrst, line, flip, wr, rd, brk_evt, byte_evt, ce;
   logic [8:0] addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic [7:0] pk [5] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
   int n_errors = 0;
   int cmp_count = 0;
   int n_brk = 0;
   int n_byte = 0;
   bfsr_top u_dut (.SYS_CLK_I(sys_clk), .NRST_I(nrst), .CE_I(ce),
      .SERIAL_LINE_IN_I(line), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
      .RDATA_O(rdata), .BREAK_EVT_O(brk_evt), .BYTE_EVT_O(byte_evt));
   bfsr_tx_model u_tx (.clk_i(sys_clk), .flip_i(flip), .line_o(line));
   // 20 MHz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // count event pulses
   always @(posedge sys_clk)
   begin
      if (brk_evt === 1'b1)
         n_brk++;
      if (byte_evt === 1'b1)
         n_byte++;
   end
   // compare and report
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one-cycle write, then a free cycle
   task automatic reg_wr(input logic [8:0] a, input logic [15:0] d);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge sys_clk);
      wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   // one-cycle read, data checked in the following cycle
   task automatic rd_chk(input logic [8:0] a, input logic [15:0] exp);
      rd <= 1'b1;
      addr <= a;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1 check(rdata, exp);
      @(posedge sys_clk);
   endtask
   // verdict and end of run
   task automatic results();
      $display("errors %0d comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // hang guard
   initial
   begin
      repeat (60000) @(posedge sys_clk);
      n_errors++;
      results();
   end
   // main sequence
   initial
   begin
      nrst = 1'b0;
      flip = 1'b0;
      ce = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 9'h000;
      wdata = 16'h0000;
      repeat (10) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      reg_wr(bfsr_pkg::REG_FIRST_SLOT, 16'h0000);
      rd_chk(bfsr_pkg::REG_FIRST_SLOT, 16'h0001);
      rd_chk(9'h010, 16'h0000);
      // write while the clock enable is low must be lost
      ce <= 1'b0;
      reg_wr(bfsr_pkg::REG_FIRST_SLOT, 16'h0003);
      ce <= 1'b1;
      rd_chk(bfsr_pkg::REG_FIRST_SLOT, 16'h0001);
      reg_wr(bfsr_pkg::REG_BUF_SIZE, 16'h0003);
      reg_wr(bfsr_pkg::REG_FIRST_SLOT, 16'h0002);
      reg_wr(bfsr_pkg::REG_CTRL, 16'h0003);
      // packet: start code and five back to back slots
      u_tx.frame_start();
      u_tx.send(8'ha5, 1'b1);
      foreach (pk[i])
         u_tx.send(pk[i], 1'b1);
      for (int i = 0; i < 3; i++)
         rd_chk(9'h100 + 9'(i), {8'h00, pk[i + 1]});
      rd_chk(bfsr_pkg::REG_START_CODE, 16'h00a5);
      rd_chk(bfsr_pkg::REG_BUS_ACT, 16'h0002);
      rd_chk(bfsr_pkg::REG_BUS_ACT, 16'h0000);
      rd_chk(bfsr_pkg::REG_SLOT_ACT, 16'h0001);
      rd_chk(bfsr_pkg::REG_SLOT_ACT, 16'h0000);
      check(16'(n_brk), 16'h0001);
      check(16'(n_byte), 16'h0006);
      // packet: first slot rewritten mid-packet, one bad stop bit
      u_tx.frame_start();
      u_tx.send(8'h00, 1'b1);
      reg_wr(bfsr_pkg::REG_FIRST_SLOT, 16'h0001);
      u_tx.send(8'h66, 1'b1);
      u_tx.send(8'h77, 1'b0);
      u_tx.send(8'h88, 1'b1);
      u_tx.send(8'h99, 1'b1);
      rd_chk(9'h100, 16'h0022);
      rd_chk(9'h101, 16'h0088);
      rd_chk(9'h102, 16'h0099);
      check(16'(n_byte), 16'h000a);
      check(16'(n_brk), 16'h0002);
      // packet on an inverted line, new first slot now active
      flip <= 1'b1;
      reg_wr(bfsr_pkg::REG_CTRL, 16'h0007);
      u_tx.frame_start();
      u_tx.send(8'h5a, 1'b1);
      u_tx.send(8'hab, 1'b1);
      // buffer rewritten mid-packet: following slot is dropped
      reg_wr(bfsr_pkg::REG_BUF_BASE, 16'h0000);
      u_tx.send(8'hcd, 1'b1);
      rd_chk(bfsr_pkg::REG_START_CODE, 16'h005a);
      rd_chk(9'h100, 16'h00ab);
      rd_chk(9'h101, 16'h0088);
      rd_chk(bfsr_pkg::REG_STATUS, 16'h0001);
      // break detector disabled: no packet is taken
      reg_wr(bfsr_pkg::REG_CTRL, 16'h0005);
      u_tx.frame_start();
      u_tx.send(8'hc3, 1'b1);
      rd_chk(bfsr_pkg::REG_START_CODE, 16'h005a);
      check(16'(n_brk), 16'h0003);
      results();
   end
endmodule
